//--- rtl/prw_pkg.sv
// constants and types for the rewriteable rom host controller
package prw_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 16;
	// unlock and command bytes, low byte only; the upper byte is don't-care
	localparam logic [15:0] UNLOCK_ADDR_A   = 16'h5555;
	localparam logic [15:0] UNLOCK_ADDR_B   = 16'h2aaa;
	localparam logic [7:0]  UNLOCK_DATA_A   = 8'haa;
	localparam logic [7:0]  UNLOCK_DATA_B   = 8'h55;
	localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CMD_ERASE_CHIP  = 8'h10;
	localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
	localparam logic [7:0]  CMD_ID_ENTRY    = 8'h90;
	localparam logic [7:0]  CMD_ID_EXIT     = 8'hf0;
	localparam logic [2:0]  ERASE_LEN       = 3'h6;
	localparam logic [2:0]  PROGRAM_LEN     = 3'h4;
	localparam logic [2:0]  ID_ENTRY_LEN    = 3'h3;
	localparam logic [2:0]  ID_EXIT_LEN     = 3'h1;
	localparam logic [15:0] ERASED_WORD     = 16'hffff;
	localparam logic [15:0] ID_MFR_ADDR     = 16'h0000;
	localparam logic [15:0] ID_DEV_ADDR     = 16'h0001;
	// timing
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          PROGRAM_TIME_NS = 20000;
	localparam int          ERASE_TIME_NS   = 500000000;
	localparam int          PROGRAM_WAIT    = PROGRAM_TIME_NS / CLK_PERIOD_NS;
	localparam int          ERASE_WAIT      = ERASE_TIME_NS / CLK_PERIOD_NS;
	// one pin cycle: setup, strobe, hold, then done
	localparam int          PIN_CYCLE_LAT   = 4;
	typedef enum logic [2:0] {
		PRW_OP_READ,
		PRW_OP_PROGRAM,
		PRW_OP_ERASE,
		PRW_OP_ID_ENTRY,
		PRW_OP_ID_EXIT
	} prw_op_t;
endpackage

//--- rtl/prw_pin_cycle.sv
// one read or write bus cycle on the rom pins
`timescale 1ns/1ns
`default_nettype none
module prw_pin_cycle (
	input  wire logic                    clock_i,
	input  wire logic                    reset_i,
	input  wire logic                    start_i,
	input  wire logic                    wr_i,
	input  wire logic [prw_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [prw_pkg::DATA_W-1:0] data_i,
	output logic                         done_o,
	output logic [prw_pkg::DATA_W-1:0]   rdata_o,
	output logic [prw_pkg::ADDR_W-1:0]   word_address_o,
	output logic                         chip_sel_n_o,
	output logic                         out_en_n_o,
	output logic                         write_n_o,
	output logic [prw_pkg::DATA_W-1:0]   data_lines_o,
	output logic                         data_lines_oe_o,
	input  wire logic [prw_pkg::DATA_W-1:0] data_lines_i
);
	import prw_pkg::*;

	typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} prw_cyc_st_t;
	typedef struct packed {
		prw_cyc_st_t       st;
		logic              wr;
		logic              done;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              doe;
	} prw_cyc_t;

	prw_cyc_t q_r;
	prw_cyc_t q_nxt;

	// sequence the phases; pins follow the next phase so they come from flops
	always_comb begin
		q_nxt      = q_r;
		q_nxt.done = 1'b0;
		unique case (q_r.st)
			CYC_IDLE: begin
				if (start_i) begin
					q_nxt.st   = CYC_SETUP;
					q_nxt.wr   = wr_i;
					q_nxt.addr = addr_i;
					q_nxt.dout = data_i;
				end
			end
			CYC_SETUP: q_nxt.st = CYC_STROBE;
			CYC_STROBE: begin
				q_nxt.st = CYC_HOLD;
				// read data has settled for two periods, far beyond access time
				if (!q_r.wr) q_nxt.rdata = data_lines_i;
			end
			CYC_HOLD: begin
				q_nxt.st   = CYC_IDLE;
				q_nxt.done = 1'b1;
			end
		endcase
		// write: oe stays high throughout, we low one whole period (100 ns)
		q_nxt.ce_n = (q_nxt.st == CYC_IDLE);
		q_nxt.oe_n = q_nxt.wr || (q_nxt.st == CYC_IDLE);
		q_nxt.we_n = !(q_nxt.wr && q_nxt.st == CYC_STROBE);
		// data held through the we rise so the device latches it
		q_nxt.doe  = q_nxt.wr && (q_nxt.st != CYC_IDLE);
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			q_r      <= '0;
			q_r.ce_n <= 1'b1;
			q_r.oe_n <= 1'b1;
			q_r.we_n <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign done_o          = q_r.done;
	assign rdata_o         = q_r.rdata;
	assign word_address_o  = q_r.addr;
	assign chip_sel_n_o    = q_r.ce_n;
	assign out_en_n_o      = q_r.oe_n;
	assign write_n_o       = q_r.we_n;
	assign data_lines_o    = q_r.dout;
	assign data_lines_oe_o = q_r.doe;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	no_oe_write_a: assert property (!write_n_o |-> out_en_n_o && !chip_sel_n_o)
		else $error("write strobe low while output enabled or chip deselected");
	strobe_width_a: assert property ($fell(write_n_o) |=> $rose(write_n_o))
		else $error("write strobe not exactly one period wide");
	data_hold_a: assert property ($rose(write_n_o) |-> data_lines_oe_o && !chip_sel_n_o && $stable(data_lines_o))
		else $error("data not held across write strobe rise");
	read_bus_a: assert property (!out_en_n_o |-> !data_lines_oe_o && write_n_o)
		else $error("bus contention during read");
	cycle_latency_a: assert property (start_i && q_r.st == CYC_IDLE |-> ##4 done_o)
		else $error("pin cycle did not finish in four periods");
	write_seen_c: cover property ($fell(write_n_o));
endmodule
`default_nettype wire

//--- rtl/prw_host.sv
// host controller driving the rewriteable rom through its pins
`timescale 1ns/1ns
`default_nettype none
module prw_host #(
	parameter int unsigned ERASE_CYCLES = prw_pkg::ERASE_WAIT
) (
	input  wire logic                       clock_i,
	input  wire logic                       reset_i,
	input  wire logic                       cmd_valid_i,
	output logic                            cmd_ready_o,
	input  wire prw_pkg::prw_op_t           cmd_op_i,
	input  wire logic [prw_pkg::ADDR_W-1:0] cmd_addr_i,
	input  wire logic [prw_pkg::DATA_W-1:0] cmd_data_i,
	output logic                            rsp_valid_o,
	output logic [prw_pkg::DATA_W-1:0]      rsp_data_o,
	output logic                            busy_o,
	output logic                            id_mode_o,
	output logic [prw_pkg::ADDR_W-1:0]      word_address_o,
	output logic                            chip_sel_n_o,
	output logic                            out_en_n_o,
	output logic                            write_n_o,
	output logic [prw_pkg::DATA_W-1:0]      data_lines_o,
	output logic                            data_lines_oe_o,
	input  wire logic [prw_pkg::DATA_W-1:0] data_lines_i
);
	import prw_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_WAIT} prw_st_t;
	typedef struct packed {
		prw_st_t           st;
		prw_op_t           op;
		logic [2:0]        idx;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [31:0]       timer;
		logic              id_mode;
		logic              rsp_valid;
		logic [DATA_W-1:0] rsp_data;
		logic              cyc_start;
		logic              cyc_wr;
		logic [ADDR_W-1:0] cyc_addr;
		logic [DATA_W-1:0] cyc_data;
	} prw_ctl_t;

	prw_ctl_t          q_r;
	prw_ctl_t          q_nxt;
	logic              cyc_done;
	logic [DATA_W-1:0] cyc_rdata;

	// number of bus writes in each command sequence
	function automatic logic [2:0] seq_len(input prw_op_t op);
		unique case (op)
			PRW_OP_ERASE:    seq_len = ERASE_LEN;
			PRW_OP_PROGRAM:  seq_len = PROGRAM_LEN;
			PRW_OP_ID_ENTRY: seq_len = ID_ENTRY_LEN;
			default:         seq_len = ID_EXIT_LEN;
		endcase
	endfunction

	// address and data of write number idx; the upper data byte is sent as zero except in the program word write
	function automatic logic [31:0] seq_step(input prw_op_t op, input logic [2:0] idx,
			input logic [15:0] ua, input logic [15:0] ud);
		logic [7:0] cmd;
		cmd = CMD_ID_ENTRY;
		if (op == PRW_OP_ERASE) cmd = CMD_ERASE_SETUP;
		if (op == PRW_OP_PROGRAM) cmd = CMD_PROGRAM;
		seq_step = {UNLOCK_ADDR_A, 8'h00, UNLOCK_DATA_A};
		unique case (idx)
			3'h0: begin
				// exit needs no unlock and takes any address
				if (op == PRW_OP_ID_EXIT) seq_step = {ua, 8'h00, CMD_ID_EXIT};
			end
			3'h1, 3'h4: seq_step = {UNLOCK_ADDR_B, 8'h00, UNLOCK_DATA_B};
			3'h2: seq_step = {UNLOCK_ADDR_A, 8'h00, cmd};
			3'h3: begin
				// the fourth program write carries the full 16-bit word
				if (op == PRW_OP_PROGRAM) seq_step = {ua, ud};
			end
			3'h5: seq_step = {UNLOCK_ADDR_A, 8'h00, CMD_ERASE_CHIP};
			default: seq_step = {UNLOCK_ADDR_A, 8'h00, UNLOCK_DATA_A};
		endcase
	endfunction

	// command sequencer; a sequence is always issued whole, so the device
	// never sees a broken one from this side
	always_comb begin
		q_nxt           = q_r;
		q_nxt.rsp_valid = 1'b0;
		q_nxt.cyc_start = 1'b0;
		unique case (q_r.st)
			ST_IDLE: begin
				// new commands only here, so nothing lands on a busy device
				if (cmd_valid_i) begin
					q_nxt.op        = cmd_op_i;
					q_nxt.addr      = cmd_addr_i;
					q_nxt.wdata     = cmd_data_i;
					q_nxt.idx       = 3'h0;
					q_nxt.st        = ST_CYCLE;
					q_nxt.cyc_start = 1'b1;
					q_nxt.cyc_wr    = (cmd_op_i != PRW_OP_READ);
					{q_nxt.cyc_addr, q_nxt.cyc_data} = seq_step(cmd_op_i, 3'h0, cmd_addr_i, cmd_data_i);
					// a read uses the caller's address as is, id words included
					if (cmd_op_i == PRW_OP_READ) q_nxt.cyc_addr = cmd_addr_i;
				end
			end
			ST_CYCLE: begin
				if (cyc_done) begin
					if (q_r.op == PRW_OP_READ) begin
						q_nxt.rsp_valid = 1'b1;
						q_nxt.rsp_data  = cyc_rdata;
						q_nxt.st        = ST_IDLE;
					end else if (q_r.idx != seq_len(q_r.op) - 3'h1) begin
						q_nxt.idx       = q_r.idx + 3'h1;
						q_nxt.cyc_start = 1'b1;
						{q_nxt.cyc_addr, q_nxt.cyc_data} = seq_step(q_r.op, q_r.idx + 3'h1, q_r.addr, q_r.wdata);
					end else begin
						unique case (q_r.op)
							PRW_OP_PROGRAM: begin
								// device pulses itself; just wait out the program time
								q_nxt.timer = 32'(PROGRAM_WAIT - 1);
								q_nxt.st    = ST_WAIT;
							end
							PRW_OP_ERASE: begin
								// the longest erase, so every word reads ones afterwards
								q_nxt.timer = 32'(ERASE_CYCLES - 1);
								q_nxt.st    = ST_WAIT;
							end
							PRW_OP_ID_ENTRY: begin
								q_nxt.id_mode   = 1'b1;
								q_nxt.rsp_valid = 1'b1;
								q_nxt.st        = ST_IDLE;
							end
							default: begin
								q_nxt.id_mode   = 1'b0;
								q_nxt.rsp_valid = 1'b1;
								q_nxt.st        = ST_IDLE;
							end
						endcase
					end
				end
			end
			ST_WAIT: begin
				if (q_r.timer == 32'h0) begin
					// device is back in read mode without any exit write
					q_nxt.rsp_valid = 1'b1;
					q_nxt.st        = ST_IDLE;
				end else begin
					q_nxt.timer = q_r.timer - 32'h1;
				end
			end
			default: q_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// pin timing lives in the cycle engine; it keeps oe high on writes
	prw_pin_cycle u_cycle (
		.clock_i         (clock_i),
		.reset_i         (reset_i),
		.start_i         (q_r.cyc_start),
		.wr_i            (q_r.cyc_wr),
		.addr_i          (q_r.cyc_addr),
		.data_i          (q_r.cyc_data),
		.done_o          (cyc_done),
		.rdata_o         (cyc_rdata),
		.word_address_o  (word_address_o),
		.chip_sel_n_o    (chip_sel_n_o),
		.out_en_n_o      (out_en_n_o),
		.write_n_o       (write_n_o),
		.data_lines_o    (data_lines_o),
		.data_lines_oe_o (data_lines_oe_o),
		.data_lines_i    (data_lines_i)
	);

	// handshake and busy are decoded from the state; data and the other flags come from flops
	assign cmd_ready_o = (q_r.st == ST_IDLE);
	assign busy_o      = (q_r.st == ST_WAIT);
	assign rsp_valid_o = q_r.rsp_valid;
	assign rsp_data_o  = q_r.rsp_data;
	assign id_mode_o   = q_r.id_mode;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	busy_refuse_a: assert property (busy_o |-> chip_sel_n_o && write_n_o)
		else $error("pin cycle started while the rom is busy");
	erase_last_a: assert property (q_r.cyc_start && q_r.op == PRW_OP_ERASE && q_r.idx == 3'h5
			|-> q_r.cyc_addr == UNLOCK_ADDR_A && q_r.cyc_data[7:0] == CMD_ERASE_CHIP)
		else $error("sixth erase write wrong");
	erase_third_a: assert property (q_r.cyc_start && q_r.op == PRW_OP_ERASE && q_r.idx == 3'h2
			|-> q_r.cyc_data[7:0] == CMD_ERASE_SETUP)
		else $error("third erase write wrong");
	prog_cmd_a: assert property (q_r.cyc_start && q_r.op == PRW_OP_PROGRAM && q_r.idx == 3'h2
			|-> q_r.cyc_addr == UNLOCK_ADDR_A && q_r.cyc_data[7:0] == CMD_PROGRAM)
		else $error("program command write wrong");
	prog_word_a: assert property (q_r.cyc_start && q_r.op == PRW_OP_PROGRAM && q_r.idx == 3'h3
			|-> q_r.cyc_addr == q_r.addr && q_r.cyc_data == q_r.wdata)
		else $error("program target write wrong");
	id_entry_a: assert property (q_r.st == ST_CYCLE && cyc_done && q_r.op == PRW_OP_ID_ENTRY
			&& q_r.idx == 3'h2 |=> id_mode_o && rsp_valid_o)
		else $error("id mode not entered after third write");
	id_exit_a: assert property (q_r.cyc_start && q_r.op == PRW_OP_ID_EXIT
			|-> q_r.cyc_data[7:0] == CMD_ID_EXIT ##5 !id_mode_o)
		else $error("id exit wrong");
	prog_wait_a: assert property ($rose(busy_o) && q_r.op == PRW_OP_PROGRAM
			|-> ##200 rsp_valid_o)
		else $error("program wait not 20 us");
	upper_byte_a: assert property (q_r.cyc_start && q_r.idx < 3'h3 && q_r.op != PRW_OP_READ
			|-> q_r.cyc_data[15:8] == 8'h00)
		else $error("command upper byte not zero");

	erase_run_c: cover property ($rose(busy_o) && q_r.op == PRW_OP_ERASE);
	prog_done_c: cover property (rsp_valid_o && q_r.op == PRW_OP_PROGRAM);
	read_done_c: cover property (rsp_valid_o && q_r.op == PRW_OP_READ && id_mode_o);
	id_exit_c: cover property ($fell(id_mode_o));
endmodule
`default_nettype wire

//--- tb/prw_rom_model.sv
// behavioural model of the rewriteable rom seen from the host pins
`timescale 1ns/1ns
`default_nettype none
module prw_rom_model #(
	parameter int          PROG_NS  = 19000,
	parameter int          ERASE_NS = 1500,
	parameter logic        LOW_SUPPLY = 1'b0, // the host side never sees a sagging supply
	parameter logic [15:0] MFR_CODE = 16'h00c3, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h00b7  // arbitrary value
) (
	input  wire logic [15:0] word_address_i,
	input  wire logic        chip_sel_n_i,
	input  wire logic        out_en_n_i,
	input  wire logic        write_n_i,
	input  wire logic [15:0] data_lines_i,
	output logic [15:0]      data_lines_o,
	output logic             data_lines_oe_o
);
	logic [15:0] mem [0:65535];
	logic [15:0] lat_addr;
	logic [15:0] float_pat = 16'h5a5a;
	logic [2:0]  step = 3'd0;
	logic        prog_next = 1'b0;
	logic        id_mode = 1'b0;
	logic        busy = 1'b0;
	logic        armed = 1'b0;
	time         t_fall;
	// output enable low inhibits writes entirely
	wire logic   wr_n = write_n_i | chip_sel_n_i | ~out_en_n_i;

	initial for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;

	// sequence decoder; any unexpected write drops back to idle
	task automatic decode(input logic [15:0] a, input logic [15:0] d);
		logic [7:0] c;
		c = d[7:0];
		if (prog_next) begin
			mem[a] = mem[a] & d;
			prog_next = 1'b0;
			busy = 1'b1;
			busy <= #PROG_NS 1'b0;
		end else if (c == 8'hf0) begin
			id_mode = 1'b0;
			step = 3'd0;
		end else begin
			case (step)
			3'd0: step = (a == 16'h5555 && c == 8'haa) ? 3'd1 : 3'd0;
			3'd1: step = (a == 16'h2aaa && c == 8'h55) ? 3'd2 : 3'd0;
			3'd2: begin
				step = (a == 16'h5555 && c == 8'h80) ? 3'd3 : 3'd0;
				prog_next = (a == 16'h5555 && c == 8'ha0);
				id_mode = id_mode | (a == 16'h5555 && c == 8'h90);
			end
			3'd3: step = (a == 16'h5555 && c == 8'haa) ? 3'd4 : 3'd0;
			3'd4: step = (a == 16'h2aaa && c == 8'h55) ? 3'd5 : 3'd0;
			default: begin
				if (a == 16'h5555 && c == 8'h10) begin
					for (int i = 0; i < 65536; i++) mem[i] = 16'hffff;
					busy = 1'b1;
					busy <= #ERASE_NS 1'b0;
				end
				step = 3'd0;
			end
			endcase
		end
	endtask

	// address at the later falling edge of strobe or select
	always @(negedge wr_n) begin
		lat_addr = word_address_i;
		t_fall = $time;
		armed = 1'b1;
	end
	// data at the earlier rising edge; short pulses are noise
	always @(posedge wr_n) begin
		if (armed && !busy && !LOW_SUPPLY && ($time - t_fall >= 15)) decode(lat_addr, data_lines_i);
		armed = 1'b0;
	end
	// floating lines show a changing pattern, never the last word
	always @(word_address_i or chip_sel_n_i or out_en_n_i) float_pat = ~float_pat;
	assign data_lines_oe_o = !chip_sel_n_i && !out_en_n_i && write_n_i;
	assign data_lines_o = !data_lines_oe_o ? float_pat :
		!id_mode ? mem[word_address_i] :
		(word_address_i == 16'h0000) ? MFR_CODE : (word_address_i == 16'h0001) ? DEV_CODE : 16'h0000;
endmodule
`default_nettype wire

//--- tb/test_prw_host.sv
// self-checking bench for the rewriteable rom host controller
`timescale 1ns/1ns
`default_nettype none
module test_prw_host;
	import prw_pkg::*;
	localparam logic [15:0] MFR = 16'h00c3; // arbitrary value
	localparam logic [15:0] DEV = 16'h00b7; // arbitrary value
	localparam int          ERASE_CYC = 20; // short erase wait keeps the run brief
	logic        clock_i, reset_i, cmd_valid_i;
	prw_op_t     cmd_op_i;
	logic [15:0] cmd_addr_i, cmd_data_i, rsp_data_o, word_address_o, host_d, dev_d;
	logic        cmd_ready_o, rsp_valid_o, busy_o, id_mode_o, chip_sel_n_o, out_en_n_o, write_n_o;
	logic        host_oe, dev_oe;
	int          error_cnt, tests_run, cycles, busy_seen;
	logic [31:0] seed;
	logic [15:0] ref_mem [int];
	logic [15:0] addrs [$];
	// whoever enables its driver owns the lines
	wire logic [15:0] bus = host_oe ? host_d : dev_d;

	prw_host #(.ERASE_CYCLES(ERASE_CYC)) i_dut (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_o(busy_o), .id_mode_o(id_mode_o),
		.word_address_o(word_address_o), .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
		.write_n_o(write_n_o), .data_lines_o(host_d), .data_lines_oe_o(host_oe), .data_lines_i(bus));
	prw_rom_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_rom (.word_address_i(word_address_o),
		.chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o), .write_n_i(write_n_o),
		.data_lines_i(bus), .data_lines_o(dev_d), .data_lines_oe_o(dev_oe));

	always #50 clock_i = ~clock_i;
	// hang guard, far above the roughly two thousand cycles the run needs
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] expect_word(input logic [15:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : 16'hffff;
	endfunction
	// negedges from take to answer: five per bus write, one to answer, plus the wait
	function automatic int exp_lat(input prw_op_t op);
		case (op)
			PRW_OP_PROGRAM:  return 5 * PROGRAM_LEN + 1 + PROGRAM_WAIT;
			PRW_OP_ERASE:    return 5 * ERASE_LEN + 1 + ERASE_CYC;
			PRW_OP_ID_ENTRY: return 5 * ID_ENTRY_LEN + 1;
			default:         return 5 * ID_EXIT_LEN + 1;
		endcase
	endfunction
	function automatic int exp_busy(input prw_op_t op);
		case (op)
			PRW_OP_PROGRAM: return PROGRAM_WAIT;
			PRW_OP_ERASE:   return ERASE_CYC;
			default:        return 0;
		endcase
	endfunction

	// the two drivers never meet, and a write strobe never sees output enable low
	always @(negedge clock_i) begin
		if (host_oe === 1'b1) check_flag(dev_oe, 1'b0, "rom drives while host drives");
		if (write_n_o === 1'b0) check_flag(out_en_n_o, 1'b1, "output enable low in write");
	end

	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %b", $time, msg, got);
		end
	endtask
	task automatic check_num(input int got, input int exp, input string msg);
		tests_run++;
		if (got != exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
		end
	endtask

	// one command: request held for the take edge, then wait for the answer
	task automatic run(input prw_op_t op, input logic [15:0] a, input logic [15:0] d,
			output logic [15:0] rd, output int lat);
		@(posedge clock_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i    <= op;
		cmd_addr_i  <= a;
		cmd_data_i  <= d;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		lat = 0;
		busy_seen = 0;
		do begin
			@(negedge clock_i);
			lat++;
			if (busy_o === 1'b1) busy_seen++;
		end while (rsp_valid_o !== 1'b1 && lat < 1000);
		rd = rsp_data_o;
		if (lat >= 1000) check_num(lat, 0, "no answer");
		check_flag(cmd_ready_o, 1'b1, "not ready with answer");
	endtask
	task automatic read_check(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] rd;
		int          lat;
		run(PRW_OP_READ, a, 16'h0000, rd, lat);
		check_word(rd, exp, "read word");
		check_num(lat, 6, "read latency");
	endtask
	// a write command: answer time against the sequence length plus the wait, busy time against the wait
	task automatic op_check(input prw_op_t op, input logic [15:0] a, input logic [15:0] d);
		logic [15:0] rd;
		int          lat;
		run(op, a, d, rd, lat);
		check_num(lat, exp_lat(op), "command latency");
		check_num(busy_seen, exp_busy(op), "busy time");
	endtask

	initial begin
		logic [15:0] a, d;
		clock_i = 1'b0;
		reset_i = 1'b1;
		cmd_valid_i = 1'b0;
		cmd_op_i = PRW_OP_READ;
		cmd_addr_i = 16'h0000;
		cmd_data_i = 16'h0000;
		error_cnt = 0;
		tests_run = 0;
		cycles = 0;
		seed = 32'h3f49fff4;
		repeat (8) @(posedge clock_i);
		check_flag(chip_sel_n_o, 1'b1, "select during reset");
		check_flag(host_oe, 1'b0, "driver during reset");
		reset_i <= 1'b0;
		// erase, then spot reads see all ones
		op_check(PRW_OP_ERASE, 16'h0000, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			read_check(seed[15:0], ERASED_WORD);
		end
		// programs: unlock address first and twice, then the top word to zero, then random places
		for (int i = 0; i < 7; i++) begin
			seed = lfsr(seed);
			a = (i < 2) ? UNLOCK_ADDR_A : (i == 2) ? 16'hffff : seed[15:0];
			d = (i == 2) ? 16'h0000 : seed[31:16];
			op_check(PRW_OP_PROGRAM, a, d);
			ref_mem[a] = expect_word(a) & d;
			addrs.push_back(a);
		end
		foreach (addrs[i]) read_check(addrs[i], expect_word(addrs[i]));
		// identification entry, code reads, exit at a random address
		op_check(PRW_OP_ID_ENTRY, 16'h0000, 16'h0000);
		check_flag(id_mode_o, 1'b1, "id mode on");
		read_check(ID_MFR_ADDR, MFR);
		read_check(ID_DEV_ADDR, DEV);
		seed = lfsr(seed);
		op_check(PRW_OP_ID_EXIT, seed[15:0], 16'h0000);
		check_flag(id_mode_o, 1'b0, "id mode off");
		read_check(UNLOCK_ADDR_A, expect_word(UNLOCK_ADDR_A));
		// second erase restores every programmed word
		op_check(PRW_OP_ERASE, 16'h0000, 16'h0000);
		foreach (addrs[i]) read_check(addrs[i], ERASED_WORD);
		give_verdict();
	end
endmodule
`default_nettype wire
